// [hdl/fifo_irq_pkg.sv]
// Constants, field layouts and carriers for the FIFO status and request block.
// Assumes a single 40 MHz clock and a host reaching registers through an address pointer.
//
// Contract
// - Eight-bit threshold, ninth bit in deep mode
// - Near-empty when count not above threshold
// - Near-full when depth minus count not above threshold
// - Depth select: one is 255, zero 512
// - Read-only byte count, resets zero, extended upward
// - Data write pushes and counts up, read pops
// - Data port accesses keep the address pointer
// - Bit 7 picks set or clear for ones
// - Request register at its address, resets zero
// - Near-full event latched until cleared
// - Near-empty event latched until cleared
// - Command finishing itself sets command-done
// - Unknown command reverts idle, sets command-done
// - Host writing idle sets no command-done
// - Transmit-done set after last bit sent
// - Receive-done set at end of stream
// - Error event on any listed fault rising
// - Frame-start event on start pattern detected
// - Enabled flags alone reach the global request
package fifo_irq_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [6:0] CMD_ADDR        = 7'h00;
	localparam logic [6:0] FIFO_CTRL_ADDR  = 7'h02;
	localparam logic [6:0] THRESHOLD_ADDR  = 7'h03;
	localparam logic [6:0] BYTE_COUNT_ADDR = 7'h04;
	localparam logic [6:0] DATA_PORT_ADDR  = 7'h05;
	localparam logic [6:0] IRQ_REQ_ADDR    = 7'h06;
	localparam logic [6:0] IRQ_EN_ADDR     = 7'h08;

	// ==========================================================
	// Field positions
	localparam int CTRL_DEPTH_BIT  = 7;
	localparam int CTRL_FULL_BIT   = 6;
	localparam int CTRL_EMPTY_BIT  = 5;
	localparam int CTRL_FLUSH_BIT  = 4;
	localparam int CTRL_LVL_MSB    = 2;
	localparam int IRQ_SET_BIT     = 7;
	localparam int IRQ_INV_BIT     = 7;
	localparam int EV_NEAR_FULL    = 6;
	localparam int EV_NEAR_EMPTY   = 5;
	localparam int EV_CMD_DONE     = 4;
	localparam int EV_TX_DONE      = 3;
	localparam int EV_RX_DONE      = 2;
	localparam int EV_ERROR        = 1;
	localparam int EV_FRAME_START  = 0;

	// ==========================================================
	// Reset values and sizes
	localparam logic [7:0] IRQ_REQ_RESET   = 8'h00;
	localparam logic [7:0] BYTE_CNT_RESET  = 8'h00;
	localparam logic [7:0] THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET    = 8'h00;
	localparam logic [4:0] CMD_IDLE        = 5'h00;
	localparam logic [9:0] DEPTH_SHALLOW   = 10'h0FF;
	localparam logic [9:0] DEPTH_DEEP      = 10'h200;
	localparam int         BUF_WIDTH       = 8;
	localparam int         BUF_DEPTH       = 32;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic tx_done;
		logic rx_done;
		logic frame_start;
		logic cmd_finish;
	} engine_events_s;

	typedef struct packed {
		logic write_fault;
		logic overrun;
		logic protocol;
		logic missing_payload;
		logic integrity;
	} fault_flags_s;

endpackage : fifo_irq_pkg

// [hdl/fifo_irq_regs.sv]
// Byte FIFO plus host register file for FIFO status and request flags.
// Assumes host accesses arrive as single-cycle strobes synchronous to ref_clk_i.
`timescale 1ns/1ps

// ==========================================================
// Byte buffer with valid/ready on both sides
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic                       ref_clk_i,
	input  wire logic                       reset_i,
	// Fill side
	input  wire logic                       in_valid_i,
	output      logic                       in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	// Drain side
	output      logic                       out_valid_o,
	input  wire logic                       out_ready_i,
	output      logic [WIDTH-1:0]           out_data_o,
	// Control and status
	input  wire logic                       flush_i,
	output      logic [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      level_r;
	logic             push;
	logic             pop;

	// Honest full and empty from the level counter
	assign in_ready_o  = (level_r != (AW+1)'(DEPTH));
	assign out_valid_o = (level_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign level_o     = level_r;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage write
	always_ff @(posedge ref_clk_i)
	begin
		if (push)
		begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	// Pointers and level; flush drops everything at once
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i || flush_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r  <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			level_r <= level_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : byte_fifo

// ==========================================================
// Register file, alerts and request flags
module fifo_irq_regs
	import fifo_irq_pkg::*;
#(
	parameter logic [31:0] CMD_VALID_MASK = 32'h0000_00FF
) (
	// Clock and reset
	input  wire logic           ref_clk_i,
	input  wire logic           reset_i,
	// Host register access
	input  wire logic           addr_load_i,
	input  wire logic [6:0]     addr_i,
	input  wire logic           wr_i,
	input  wire logic [7:0]     wdata_i,
	input  wire logic           rd_i,
	output      logic [7:0]     rdata_o,
	output      logic           rdata_valid_o,
	// Receive path bytes into the buffer
	input  wire logic           rx_valid_i,
	output      logic           rx_ready_o,
	input  wire logic [7:0]     rx_data_i,
	// Transmit path bytes out of the buffer
	output      logic           tx_valid_o,
	input  wire logic           tx_ready_i,
	output      logic [7:0]     tx_data_o,
	// Engine events and faults
	input  wire engine_events_s events_i,
	input  wire fault_flags_s   faults_i,
	// Command and request outputs
	output      logic [4:0]     command_o,
	output      logic           global_request_o,
	output      logic           irq_pin_o
);
	// ==========================================================
	// State
	logic [6:0]   ptr_r;
	logic [4:0]   command_r;
	logic [7:0]   threshold_r;
	logic         depth_sel_r;
	logic         lvl_msb_r;
	logic [6:0]   irq_req_r;
	logic [7:0]   irq_en_r;
	logic         near_full_q_r;
	logic         near_empty_q_r;
	fault_flags_s faults_q_r;
	logic         wr_fault_r;
	logic         wr_fault_q_r;
	logic         flush_r;

	// ==========================================================
	// Decode
	logic             host_push;
	logic             host_pop;
	logic             fifo_in_valid;
	logic             fifo_in_ready;
	logic [7:0]       fifo_in_data;
	logic             fifo_out_valid;
	logic             fifo_out_ready;
	logic [7:0]       fifo_out_data;
	logic [5:0]       fifo_level;
	logic [9:0]       byte_count;
	logic [9:0]       depth;
	logic [9:0]       level;
	logic             fifo_near_full_flag;
	logic             fifo_near_empty_flag;
	logic [6:0]       hw_set;
	logic [6:0]       sw_set;
	logic [6:0]       sw_clr;
	logic             err_rise;
	logic             cmd_wr;
	logic             cmd_unknown;

	assign host_push  = wr_i && (ptr_r == DATA_PORT_ADDR);
	assign host_pop   = rd_i && (ptr_r == DATA_PORT_ADDR);
	assign cmd_wr     = wr_i && (ptr_r == CMD_ADDR);
	assign cmd_unknown = cmd_wr && !CMD_VALID_MASK[wdata_i[4:0]];

	// ==========================================================
	// Buffer: host access wins the shared port, the engine side stalls
	assign fifo_in_valid  = host_push || rx_valid_i;
	assign fifo_in_data   = host_push ? wdata_i : rx_data_i;
	assign rx_ready_o     = fifo_in_ready && !host_push;
	assign fifo_out_ready = host_pop || tx_ready_i;
	assign tx_valid_o     = fifo_out_valid && !host_pop;
	assign tx_data_o      = fifo_out_data;

	byte_fifo #(
		.WIDTH (BUF_WIDTH),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.ref_clk_i   (ref_clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_in_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data),
		.flush_i     (flush_r),
		.level_o     (fifo_level)
	);

	// ==========================================================
	// Alert levels; the ninth threshold bit only counts in deep mode
	assign byte_count = 10'(fifo_level);
	assign depth      = depth_sel_r ? DEPTH_SHALLOW : DEPTH_DEEP;
	assign level      = {1'b0, (lvl_msb_r && !depth_sel_r), threshold_r};
	assign fifo_near_empty_flag = (byte_count <= level);
	assign fifo_near_full_flag  = ((depth - byte_count) <= level);

	// Address pointer: steps after each access except at the data port
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			ptr_r <= 7'h00;
		end
		else if (addr_load_i)
		begin
			ptr_r <= addr_i;
		end
		else if ((wr_i || rd_i) && (ptr_r != DATA_PORT_ADDR))
		begin
			ptr_r <= ptr_r + 7'h01;
		end
	end

	// Control registers written by the host; flush is a one-cycle pulse
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			threshold_r <= THRESHOLD_RESET;
			depth_sel_r <= CTRL_RESET[CTRL_DEPTH_BIT];
			lvl_msb_r   <= CTRL_RESET[CTRL_LVL_MSB];
			irq_en_r    <= IRQ_EN_RESET;
			flush_r     <= 1'b0;
		end
		else
		begin
			flush_r <= wr_i && (ptr_r == FIFO_CTRL_ADDR) && wdata_i[CTRL_FLUSH_BIT];
			if (wr_i && (ptr_r == THRESHOLD_ADDR))
			begin
				threshold_r <= wdata_i;
			end
			if (wr_i && (ptr_r == FIFO_CTRL_ADDR))
			begin
				depth_sel_r <= wdata_i[CTRL_DEPTH_BIT];
				lvl_msb_r   <= wdata_i[CTRL_LVL_MSB];
			end
			if (wr_i && (ptr_r == IRQ_EN_ADDR))
			begin
				irq_en_r <= wdata_i;
			end
		end
	end

	// Command field: unknown codes fall back to idle at once
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			command_r <= CMD_IDLE;
		end
		else if (cmd_wr)
		begin
			command_r <= cmd_unknown ? CMD_IDLE : wdata_i[4:0];
		end
		else if (events_i.cmd_finish && (command_r != CMD_IDLE))
		begin
			command_r <= CMD_IDLE;
		end
	end

	// Edge history so a level that stays high raises its event only once
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			near_full_q_r  <= 1'b0;
			near_empty_q_r <= 1'b0;
			faults_q_r     <= '0;
			wr_fault_r     <= 1'b0;
			wr_fault_q_r   <= 1'b0;
		end
		else
		begin
			near_full_q_r  <= fifo_near_full_flag;
			near_empty_q_r <= fifo_near_empty_flag;
			faults_q_r     <= faults_i;
			wr_fault_r     <= host_push && !fifo_in_ready; // Byte dropped when full
			wr_fault_q_r   <= wr_fault_r;
		end
	end

	// ==========================================================
	// Request flags: hardware set beats a same-cycle clear
	assign err_rise = ((faults_i & ~faults_q_r) != '0) || (wr_fault_r && !wr_fault_q_r);
	assign hw_set[EV_NEAR_FULL]   = fifo_near_full_flag && !near_full_q_r;
	assign hw_set[EV_NEAR_EMPTY]  = fifo_near_empty_flag && !near_empty_q_r;
	assign hw_set[EV_CMD_DONE]    = cmd_unknown
		|| (events_i.cmd_finish && (command_r != CMD_IDLE) && !cmd_wr);
	assign hw_set[EV_TX_DONE]     = events_i.tx_done;
	assign hw_set[EV_RX_DONE]     = events_i.rx_done;
	assign hw_set[EV_ERROR]       = err_rise;
	assign hw_set[EV_FRAME_START] = events_i.frame_start;
	assign sw_set = (wr_i && (ptr_r == IRQ_REQ_ADDR) && wdata_i[IRQ_SET_BIT]) ? wdata_i[6:0]
		: 7'h00;
	assign sw_clr = (wr_i && (ptr_r == IRQ_REQ_ADDR) && !wdata_i[IRQ_SET_BIT]) ? wdata_i[6:0]
		: 7'h00;

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			irq_req_r <= IRQ_REQ_RESET[6:0];
		end
		else
		begin
			irq_req_r <= (irq_req_r & ~sw_clr) | sw_set | hw_set;
		end
	end

	// Global request and pin, the pin optionally inverted
	assign global_request_o = ((irq_req_r & irq_en_r[6:0]) != 7'h00);
	assign irq_pin_o        = global_request_o ^ irq_en_r[IRQ_INV_BIT];
	assign command_o        = command_r;

	// ==========================================================
	// Read data, registered one cycle after the strobe
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			rdata_o       <= 8'h00;
			rdata_valid_o <= 1'b0;
		end
		else
		begin
			rdata_valid_o <= rd_i;
			if (rd_i)
			begin
				unique case (ptr_r)
					CMD_ADDR:        rdata_o <= {3'h0, command_r};
					FIFO_CTRL_ADDR:  rdata_o <= {depth_sel_r, fifo_near_full_flag,
						fifo_near_empty_flag, 2'b00, lvl_msb_r,
						depth_sel_r ? 2'b00 : byte_count[9:8]};
					THRESHOLD_ADDR:  rdata_o <= threshold_r;
					BYTE_COUNT_ADDR: rdata_o <= byte_count[7:0];
					DATA_PORT_ADDR:  rdata_o <= fifo_out_valid ? fifo_out_data : 8'h00;
					IRQ_REQ_ADDR:    rdata_o <= {1'b0, irq_req_r};
					IRQ_EN_ADDR:     rdata_o <= irq_en_r;
					default:         rdata_o <= 8'h00; // Unmapped reads as zero
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	property p_reset_clear;
		@(posedge ref_clk_i) reset_i |=> (irq_req_r == 7'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("flags not zero after reset");

	property p_sw_set;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && ptr_r == IRQ_REQ_ADDR && wdata_i[7]) |=> ((irq_req_r & $past(wdata_i[6:0]))
			== $past(wdata_i[6:0]));
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("set write missed a flag");

	property p_sw_clr;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && ptr_r == IRQ_REQ_ADDR && !wdata_i[7] && hw_set == 7'h00)
			|=> ((irq_req_r & $past(wdata_i[6:0])) == 7'h00);
	endproperty
	a_sw_clr: assert property (p_sw_clr) else $error("clear write left a flag");

	property p_near_full_latch;
		@(posedge ref_clk_i) disable iff (reset_i)
		$rose(fifo_near_full_flag) |=> irq_req_r[EV_NEAR_FULL] [*2];
	endproperty
	a_near_full_latch: assert property (p_near_full_latch) else $error("near-full lost");

	property p_near_empty_eq;
		@(posedge ref_clk_i) disable iff (reset_i)
		(fifo_level == 6'h00) |-> fifo_near_empty_flag;
	endproperty
	a_near_empty_eq: assert property (p_near_empty_eq) else $error("empty not near-empty");

	property p_unknown_cmd;
		@(posedge ref_clk_i) disable iff (reset_i)
		cmd_unknown |=> (command_r == CMD_IDLE) && irq_req_r[EV_CMD_DONE];
	endproperty
	a_unknown_cmd: assert property (p_unknown_cmd) else $error("unknown command kept");

	property p_idle_write;
		@(posedge ref_clk_i) disable iff (reset_i)
		(cmd_wr && wdata_i[4:0] == CMD_IDLE && !irq_req_r[EV_CMD_DONE])
			|=> !irq_req_r[EV_CMD_DONE];
	endproperty
	a_idle_write: assert property (p_idle_write) else $error("idle write set done");

	property p_ptr_hold;
		@(posedge ref_clk_i) disable iff (reset_i)
		((wr_i || rd_i) && !addr_load_i && ptr_r == DATA_PORT_ADDR) |=> $stable(ptr_r);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved at data port");

	property p_push_count;
		@(posedge ref_clk_i) disable iff (reset_i)
		(host_push && fifo_in_ready && !fifo_out_ready && !flush_r)
			|=> (byte_count == $past(byte_count) + 10'h001);
	endproperty
	a_push_count: assert property (p_push_count) else $error("push did not count");

	property p_global;
		@(posedge ref_clk_i) disable iff (reset_i)
		(irq_en_r[6:0] == 7'h00) |-> !global_request_o;
	endproperty
	a_global: assert property (p_global) else $error("masked flag reached global");

	property p_bit7_zero;
		@(posedge ref_clk_i) disable iff (reset_i)
		(rd_i && ptr_r == IRQ_REQ_ADDR) |=> !rdata_o[7];
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("selector read as one");
endmodule : fifo_irq_regs

// [verification/stream_engine_model.sv]
// Behavioural stream engine on the buffer side of the register block.
// Assumes the bench commands when to offer bytes, when to drain, and whether to stall.
`timescale 1ns/1ps

// ==========================================================
// Byte source into the buffer and byte sink out of it
module stream_engine_model (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	// Commands from the bench
	input  wire logic       push_i,
	input  wire logic       drain_i,
	input  wire logic       slow_i,
	// Receive bytes into the buffer
	output      logic       rx_valid_o,
	input  wire logic       rx_ready_i,
	output      logic [7:0] rx_data_o,
	// Transmit bytes out of the buffer
	input  wire logic       tx_valid_i,
	output      logic       tx_ready_o,
	input  wire logic [7:0] tx_data_i,
	// Last byte drained and how many
	output      logic [7:0] got_o,
	output      logic [7:0] got_cnt_o
);
	logic [7:0] seq_r;
	logic       tick_r;

	// Idle line shows the inverse, so a stale byte can never pass as fresh
	assign rx_data_o  = rx_valid_o ? seq_r : ~seq_r;
	// Slow mode stalls every other cycle
	assign tx_ready_o = drain_i & ~(slow_i & tick_r);

	// Offer is held until taken; bytes count up from 40h
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			rx_valid_o <= 1'b0;
			seq_r      <= 8'h40;
		end
		else
		begin
			if (!rx_valid_o || rx_ready_i)
				rx_valid_o <= push_i;
			if (rx_valid_o && rx_ready_i)
				seq_r <= seq_r + 8'h01;
		end
	end

	// Sink records what leaves the buffer
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			tick_r    <= 1'b0;
			got_o     <= 8'h00;
			got_cnt_o <= 8'h00;
		end
		else
		begin
			tick_r <= ~tick_r;
			if (tx_valid_i && tx_ready_o)
			begin
				got_o     <= tx_data_i;
				got_cnt_o <= got_cnt_o + 8'h01;
			end
		end
	end
endmodule : stream_engine_model

// [verification/tb_fifo_irq_regs.sv]
// Self-checking bench for the FIFO status and request register block.
// Assumes the stream engine model on the buffer side and a 40 MHz clock.
`timescale 1ns/1ps

// ==========================================================
// Top of the bench
module tb_fifo_irq_regs import fifo_irq_pkg::*;;
	logic           ref_clk_i = 1'b0;
	logic           reset_i   = 1'b1;
	logic           addr_load_i;
	logic [6:0]     addr_i;
	logic           wr_i;
	logic [7:0]     wdata_i;
	logic           rd_i;
	logic [7:0]     rdata_o;
	logic           rdata_valid_o;
	logic           rx_valid_i;
	logic           rx_ready_o;
	logic [7:0]     rx_data_i;
	logic           tx_valid_o;
	logic           tx_ready_i;
	logic [7:0]     tx_data_o;
	engine_events_s events_i;
	fault_flags_s   faults_i;
	logic [4:0]     command_o;
	logic           global_request_o;
	logic           irq_pin_o;
	logic           push;
	logic           drain;
	logic           slow;
	logic [7:0]     got;
	logic [7:0]     got_cnt;
	int             failures;
	int             total_checks;
	int             k;
	logic [3:0]     ev_tab [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
	logic [7:0]     ev_exp [4] = '{8'h08, 8'h04, 8'h01, 8'h00};

	// 25 ns period
	always #12.5 ref_clk_i = ~ref_clk_i;

	fifo_irq_regs dut (.ref_clk_i, .reset_i, .addr_load_i, .addr_i, .wr_i, .wdata_i, .rd_i,
		.rdata_o, .rdata_valid_o, .rx_valid_i, .rx_ready_o, .rx_data_i, .tx_valid_o,
		.tx_ready_i, .tx_data_o, .events_i, .faults_i, .command_o, .global_request_o,
		.irq_pin_o);

	stream_engine_model engine (.ref_clk_i, .reset_i, .push_i(push), .drain_i(drain),
		.slow_i(slow), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
		.rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.tx_data_i(tx_data_o), .got_o(got), .got_cnt_o(got_cnt));

	// ==========================================================
	// Checking and closing
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic print_verdict();
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// A wait that ran out ends the run at once
	task automatic guard(input logic ok);
		if (!ok)
		begin
			failures++;
			print_verdict();
		end
	endtask : guard

	// ==========================================================
	// Host access: strobes last one cycle, an idle cycle between
	task automatic acc(input logic ld, input logic [6:0] a, input logic w,
		input logic [7:0] d, input logic r);
		@(posedge ref_clk_i);
		addr_load_i <= ld;
		addr_i      <= a;
		wr_i        <= w;
		wdata_i     <= d;
		rd_i        <= r;
		@(posedge ref_clk_i);
		addr_load_i <= 1'b0;
		wr_i        <= 1'b0;
		rd_i        <= 1'b0;
	endtask : acc

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		acc(1'b1, a, 1'b0, 8'h00, 1'b0);
		acc(1'b0, 7'h00, 1'b1, d, 1'b0);
	endtask : wr

	// Answer lands one cycle after the strobe is taken
	task automatic rd(input logic ld, input logic [6:0] a, input logic [7:0] exp, input string n);
		if (ld)
			acc(1'b1, a, 1'b0, 8'h00, 1'b0);
		acc(1'b0, 7'h00, 1'b0, 8'h00, 1'b1);
		#1;
		chk("read valid", {7'h00, rdata_valid_o}, 8'h01);
		chk(n, rdata_o, exp);
	endtask : rd

	// ==========================================================
	// Main sequence
	initial
	begin
		{addr_load_i, wr_i, rd_i, push, drain, slow} = '0;
		addr_i = '0;
		wdata_i = '0;
		events_i = '0;
		faults_i = '0;
		failures = 0;
		total_checks = 0;
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(1'b1, BYTE_COUNT_ADDR, 8'h00, "count");
		rd(1'b1, IRQ_REQ_ADDR, 8'h20, "flags");
		rd(1'b1, FIFO_CTRL_ADDR, 8'h20, "control");
		wr(IRQ_REQ_ADDR, 8'hFF);
		rd(1'b1, IRQ_REQ_ADDR, 8'h7F, "flags");
		wr(IRQ_REQ_ADDR, 8'h7F);
		rd(1'b1, IRQ_REQ_ADDR, 8'h00, "flags");
		wr(IRQ_REQ_ADDR, 8'h85);
		wr(IRQ_REQ_ADDR, 8'h01);
		rd(1'b1, IRQ_REQ_ADDR, 8'h04, "flags");
		wr(IRQ_REQ_ADDR, 8'h7F);
		// Burst into the data port without reloading the pointer
		acc(1'b1, DATA_PORT_ADDR, 1'b0, 8'h00, 1'b0);
		for (k = 0; k < 3; k++)
			acc(1'b0, 7'h00, 1'b1, 8'hA1 + 8'(k), 1'b0);
		rd(1'b1, BYTE_COUNT_ADDR, 8'h03, "count");
		wr(THRESHOLD_ADDR, 8'h01);
		rd(1'b0, 7'h00, 8'h03, "stepped count");
		rd(1'b0, 7'h00, 8'hA1, "data");
		rd(1'b0, 7'h00, 8'hA2, "data");
		rd(1'b1, IRQ_REQ_ADDR, 8'h20, "flags");
		rd(1'b1, DATA_PORT_ADDR, 8'hA3, "data");
		rd(1'b1, BYTE_COUNT_ADDR, 8'h00, "count");
		// Fill to refusal, deep mode with a nine-bit threshold of 480
		wr(THRESHOLD_ADDR, 8'hE0);
		wr(FIFO_CTRL_ADDR, 8'h04);
		wr(IRQ_REQ_ADDR, 8'h7F);
		@(posedge ref_clk_i);
		push <= 1'b1;
		for (k = 0; k < 100 && rx_ready_o !== 1'b0; k++)
		begin
			@(posedge ref_clk_i);
			#1;
		end
		guard(rx_ready_o === 1'b0);
		@(posedge ref_clk_i);
		push <= 1'b0;
		rd(1'b1, FIFO_CTRL_ADDR, 8'h64, "control");
		rd(1'b1, BYTE_COUNT_ADDR, 8'h20, "count");
		rd(1'b1, IRQ_REQ_ADDR, 8'h40, "flags");
		wr(FIFO_CTRL_ADDR, 8'h80);
		rd(1'b1, FIFO_CTRL_ADDR, 8'hE0, "control");
		wr(DATA_PORT_ADDR, 8'h99);
		rd(1'b1, IRQ_REQ_ADDR, 8'h42, "flags");
		// Drain with a stalling sink; the held offer enters as a 33rd byte
		@(posedge ref_clk_i);
		drain <= 1'b1;
		slow  <= 1'b1;
		for (k = 0; k < 400 && got_cnt !== 8'd33; k++)
			@(posedge ref_clk_i);
		guard(got_cnt === 8'd33);
		chk("drained byte", got, 8'h60);
		rd(1'b1, BYTE_COUNT_ADDR, 8'h00, "count");
		// Live near-full has dropped, the latched event must stay
		rd(1'b1, IRQ_REQ_ADDR, 8'h42, "flags");
		// Flush drops stored bytes at once; the sink is parked first
		@(posedge ref_clk_i);
		drain <= 1'b0;
		acc(1'b1, DATA_PORT_ADDR, 1'b0, 8'h00, 1'b0);
		acc(1'b0, 7'h00, 1'b1, 8'h5A, 1'b0);
		acc(1'b0, 7'h00, 1'b1, 8'h5B, 1'b0);
		rd(1'b1, BYTE_COUNT_ADDR, 8'h02, "count");
		wr(FIFO_CTRL_ADDR, 8'h90);
		rd(1'b1, FIFO_CTRL_ADDR, 8'hA0, "control");
		rd(1'b1, BYTE_COUNT_ADDR, 8'h00, "count");
		// Engine events, one at a time
		for (k = 0; k < 4; k++)
		begin
			wr(IRQ_REQ_ADDR, 8'h7F);
			@(posedge ref_clk_i);
			events_i <= engine_events_s'(ev_tab[k]);
			@(posedge ref_clk_i);
			events_i <= '0;
			rd(1'b1, IRQ_REQ_ADDR, ev_exp[k], "event flags");
		end
		wr(IRQ_REQ_ADDR, 8'h7F);
		wr(CMD_ADDR, 8'h03);
		@(posedge ref_clk_i);
		events_i <= engine_events_s'(4'h1);
		@(posedge ref_clk_i);
		events_i <= '0;
		rd(1'b1, IRQ_REQ_ADDR, 8'h10, "flags");
		chk("command", {3'b000, command_o}, 8'h00);
		wr(IRQ_REQ_ADDR, 8'h7F);
		wr(CMD_ADDR, 8'h1F);
		rd(1'b1, CMD_ADDR, 8'h00, "command");
		rd(1'b1, IRQ_REQ_ADDR, 8'h10, "flags");
		wr(IRQ_REQ_ADDR, 8'h7F);
		wr(CMD_ADDR, 8'h00);
		rd(1'b1, IRQ_REQ_ADDR, 8'h00, "flags");
		// Each fault line on its own
		for (k = 0; k < 5; k++)
		begin
			@(posedge ref_clk_i);
			faults_i <= fault_flags_s'(5'h01 << k);
			rd(1'b1, IRQ_REQ_ADDR, 8'h02, "error flag");
			@(posedge ref_clk_i);
			faults_i <= '0;
			wr(IRQ_REQ_ADDR, 8'h7F);
		end
		// Enable gating and pin inversion
		wr(IRQ_EN_ADDR, 8'h01);
		#1;
		chk("global request", {7'h00, global_request_o}, 8'h00);
		wr(IRQ_REQ_ADDR, 8'h81);
		#1;
		chk("global request", {7'h00, global_request_o}, 8'h01);
		chk("request pin", {7'h00, irq_pin_o}, 8'h01);
		wr(IRQ_EN_ADDR, 8'h80);
		#1;
		chk("global request", {7'h00, global_request_o}, 8'h00);
		chk("request pin", {7'h00, irq_pin_o}, 8'h01);
		rd(1'b1, 7'h50, 8'h00, "unmapped");
		// Mid-run reset wipes flags and enables; near-empty rises afresh
		@(posedge ref_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(1'b1, IRQ_REQ_ADDR, 8'h20, "flags after reset");
		chk("request pin", {7'h00, irq_pin_o}, 8'h00);
		print_verdict();
	end
endmodule : tb_fifo_irq_regs
